// ==== design/vpw_codec.sv ====
/*
  Variable pulse width symbol codec with bitwise arbitration: sends bytes
  from a small FIFO as symbols on the bus and classifies received periods.
  Assumes a transceiver: txActive high drives the bus active, rxLine high
  means the bus is active; rxLine is asynchronous to clk_sys.
*/
`timescale 1ns/10ps
`include "vpw_codec_defs.svh"

module vpw_codec #(
  parameter int CW         = 12,
  parameter int FIFO_DEPTH = 4,
  parameter int GUARD_CYC  = `VPW_GUARD_CYC,
  parameter bit NB_VALUE   = 1'b0,
  parameter int P_INV_MAX  = `VPW_CYC(`VPW_RX_INV_US) - 1,
  parameter int P_ZERO_MAX = `VPW_CYC(`VPW_RX_SHORT_US) - 1,
  parameter int P_ONE_MAX  = `VPW_CYC(`VPW_RX_LONG_US) - 1,
  parameter int P_EOD_MAX  = `VPW_CYC(`VPW_T_BRK_US) - 1,
  parameter int P_EOF_MAX  = `VPW_CYC(`VPW_T_EOF_US) - 1,
  parameter int P_IFS_MAX  = `VPW_CYC(`VPW_T_IFS_US),
  parameter int A_INV_MAX  = `VPW_CYC(`VPW_RX_INV_US) - 1,
  parameter int A_ONE_MAX  = `VPW_CYC(`VPW_RX_SHORT_US) - 1,
  parameter int A_ZERO_MAX = `VPW_CYC(`VPW_RX_LONG_US) - 1,
  parameter int A_SOF_MAX  = `VPW_CYC(`VPW_T_BRK_US) - 1
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       rxLine,
  input  wire logic [7:0] txData,
  input  wire logic       txLast,
  input  wire logic       txIfr,
  input  wire logic       txValid,
  output logic            txReady,
  output logic            txActive,
  output logic            txBusy,
  output logic            txDone,
  output logic            arbLost,
  output logic [7:0]      rxByte,
  output logic            rxByteValid,
  output vpw_pkg::sym_t   symCode,
  output logic            symValid,
  output logic            busIdle
);
  // ****************************************************************
  // Elaboration checks and derived counts
  // ****************************************************************
  localparam int MAXC = (1 << CW) - 2;
  if (!(P_INV_MAX < P_ZERO_MAX && P_ZERO_MAX < P_ONE_MAX &&
        P_ONE_MAX < P_EOD_MAX && P_EOD_MAX < P_EOF_MAX &&
        P_EOF_MAX < P_IFS_MAX && P_IFS_MAX < MAXC &&
        A_INV_MAX < A_ONE_MAX && A_ONE_MAX < A_ZERO_MAX &&
        A_ZERO_MAX < A_SOF_MAX && A_SOF_MAX < MAXC)) begin : g_win
    $error("vpw_codec: receive windows must ascend and fit CW");
  end
  if (GUARD_CYC < 3 || GUARD_CYC > 15) begin : g_grd
    $error("vpw_codec: GUARD_CYC must lie in 3..15");
  end
  if (`VPW_T_EOD_US + `VPW_T_EOF_EXT_US != `VPW_T_EOF_US ||
      `VPW_T_EOF_US + `VPW_T_IFS_EXT_US != `VPW_T_IFS_US) begin : g_eof
    $error("vpw_codec: frame end times inconsistent");
  end
  if ((`VPW_T_SHORT_US + `VPW_T_LONG_US) / 2 !=
      1000000 / `VPW_RATE_BPS) begin : g_rate
    $error("vpw_codec: symbol times do not match the bit rate");
  end

  localparam logic [CW-1:0] SHORT = CW'(`VPW_CYC(`VPW_T_SHORT_US));
  localparam logic [CW-1:0] LONG  = CW'(`VPW_CYC(`VPW_T_LONG_US));
  localparam logic [CW-1:0] SOFC  = CW'(`VPW_CYC(`VPW_T_SOF_US));
  localparam logic [CW-1:0] EODC  = CW'(`VPW_CYC(`VPW_T_EOD_US));
  localparam logic [CW-1:0] BRKC  = CW'(`VPW_CYC(`VPW_T_BRK_US));
  localparam logic [3:0]    GRD   = 4'(GUARD_CYC);

  // Logic 1 is long when passive, logic 0 is long when active
  function automatic logic [CW-1:0] bitDur(input logic act,
                                           input logic val);
    bitDur = (act ^ val) ? LONG - 1'b1 : SHORT - 1'b1;
  endfunction

  // ****************************************************************
  // Receive timing and symbol classification
  // ****************************************************************
  logic          busLvl;
  logic          rise;
  logic          fall;
  logic [CW-1:0] cnt;

  vpw_rx_timer #(.CW(CW)) u_timer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .lineIn  (rxLine),
    .lvl     (busLvl),
    .rise    (rise),
    .fall    (fall),
    .cnt     (cnt)
  );

  // Each window ends at its bound; the next begins one cycle later
  vpw_pkg::sym_t pasCls;
  vpw_pkg::sym_t actCls;
  vpw_pkg::sym_t runSym;
  vpw_pkg::sym_t symNow;
  assign pasCls = (cnt <= CW'(P_INV_MAX))  ? vpw_pkg::SYM_INV :
                  (cnt <= CW'(P_ZERO_MAX)) ? vpw_pkg::SYM_ZERO :
                  (cnt <= CW'(P_ONE_MAX))  ? vpw_pkg::SYM_ONE :
                                             vpw_pkg::SYM_NONE;
  assign actCls = (cnt <= CW'(A_INV_MAX))  ? vpw_pkg::SYM_INV :
                  (cnt <= CW'(A_ONE_MAX))  ? vpw_pkg::SYM_ONE :
                  (cnt <= CW'(A_ZERO_MAX)) ? vpw_pkg::SYM_ZERO :
                  (cnt <= CW'(A_SOF_MAX))  ? vpw_pkg::SYM_SOF :
                                             vpw_pkg::SYM_INV;
  // Long symbols are announced as their bound passes, not at the edge
  assign runSym =
    busLvl ? ((cnt == CW'(A_SOF_MAX + 1)) ? vpw_pkg::SYM_BRK
                                          : vpw_pkg::SYM_NONE) :
    (cnt == CW'(P_ONE_MAX + 1)) ? vpw_pkg::SYM_EOD :
    (cnt == CW'(P_EOD_MAX + 1)) ? vpw_pkg::SYM_EOF :
    (cnt == CW'(P_EOF_MAX + 1)) ? vpw_pkg::SYM_IFS :
    (cnt == CW'(P_IFS_MAX + 1)) ? vpw_pkg::SYM_IDLE :
                                  vpw_pkg::SYM_NONE;
  // A break that already ended the active period is not an edge symbol
  assign symNow =
    (rise && pasCls != vpw_pkg::SYM_NONE) ? pasCls :
    (fall && cnt <= CW'(A_SOF_MAX)) ? actCls : runSym;

  wire bitEv  = symNow == vpw_pkg::SYM_ZERO || symNow == vpw_pkg::SYM_ONE;
  wire brkEv  = symNow == vpw_pkg::SYM_BRK;
  wire eodTime = !busLvl && cnt == EODC;

  logic       inFrame_r;
  logic       nbWait_r;
  logic       eofSeen_r;
  logic [7:0] rxSh_r;
  logic [2:0] rxCnt_r;
  wire  [7:0] rxSh_nxt = {rxSh_r[6:0], symNow == vpw_pkg::SYM_ONE};
  wire        takeBit = bitEv && inFrame_r && !nbWait_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      symCode     <= vpw_pkg::SYM_NONE;
      symValid    <= 1'b0;
      rxByte      <= 8'h00;
      rxByteValid <= 1'b0;
      busIdle     <= 1'b0;
      eofSeen_r   <= 1'b0;
      inFrame_r   <= 1'b0;
      nbWait_r    <= 1'b0;
      rxSh_r      <= 8'h00;
      rxCnt_r     <= 3'h0;
    end else begin
      symCode     <= symNow;
      symValid    <= symNow != vpw_pkg::SYM_NONE;
      rxByteValid <= takeBit && rxCnt_r == 3'h7;
      if (takeBit && rxCnt_r == 3'h7) begin
        rxByte <= rxSh_nxt;
      end
      if (takeBit) begin
        rxSh_r  <= rxSh_nxt;
        rxCnt_r <= rxCnt_r + 3'h1;
      end
      busIdle   <= (busIdle || symNow == vpw_pkg::SYM_IDLE) && !rise;
      eofSeen_r <= (eofSeen_r || symNow == vpw_pkg::SYM_EOF) && !rise;
      unique case (symNow)
        vpw_pkg::SYM_SOF: begin
          inFrame_r <= 1'b1;
          nbWait_r  <= 1'b0;
          rxCnt_r   <= 3'h0;
        end
        vpw_pkg::SYM_EOD: begin
          nbWait_r  <= 1'b1;
          rxCnt_r   <= 3'h0;
        end
        vpw_pkg::SYM_ZERO, vpw_pkg::SYM_ONE: begin
          nbWait_r  <= 1'b0;
        end
        vpw_pkg::SYM_NONE: begin
        end
        default: begin
          inFrame_r <= 1'b0;
          nbWait_r  <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Transmit buffer and symbol sender
  // ****************************************************************
  logic [9:0] head;
  logic       fifoValid;
  logic       popTx;

  vpw_fifo #(.W(10), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .inData   ({txLast, txIfr, txData}),
    .inValid  (txValid),
    .inReady  (txReady),
    .outData  (head),
    .outValid (fifoValid),
    .outReady (popTx)
  );

  vpw_pkg::tx_state_t st_r;
  vpw_pkg::tx_state_t st_nxt;
  logic          act_nxt;
  logic [CW-1:0] tmr_r;
  logic [CW-1:0] tmr_nxt;
  logic [7:0]    sh_r;
  logic [7:0]    sh_nxt;
  logic [2:0]    idx_r;
  logic [2:0]    idx_nxt;
  logic          last_r;
  logic          last_nxt;
  logic          e8_r;
  logic          e8_nxt;
  logic [3:0]    grd_r;
  logic [3:0]    grd_nxt;
  logic          flush_r;
  logic          flush_nxt;
  logic          done_nxt;
  logic          lost_nxt;

  wire symEnd  = tmr_r == '0;
  wire sending = st_r != vpw_pkg::TX_IDLE && st_r != vpw_pkg::TX_SYNC;
  wire mismatch = sending && grd_r == 4'h0 && busLvl != txActive;
  wire abortEv = mismatch || (st_r != vpw_pkg::TX_IDLE && brkEv);
  // Only a loss seen as the guard after our 8th bit runs out earns extras
  wire loss8   = mismatch && e8_r &&
                 (st_r == vpw_pkg::TX_BIT || st_r == vpw_pkg::TX_EOD);
  wire canGo   = st_r == vpw_pkg::TX_IDLE && !flush_r && fifoValid;
  // A waiting sender also joins a frame whose edge follows end of frame
  wire startSof = canGo && !head[8] &&
                  (busIdle || (eofSeen_r && rise));
  wire startNb  = canGo && head[8] && inFrame_r && eodTime;

  always_comb begin
    st_nxt    = st_r;
    act_nxt   = txActive;
    tmr_nxt   = symEnd ? tmr_r : tmr_r - 1'b1;
    sh_nxt    = sh_r;
    idx_nxt   = idx_r;
    last_nxt  = last_r;
    e8_nxt    = e8_r && grd_r != 4'h0;
    grd_nxt   = (grd_r == 4'h0) ? grd_r : grd_r - 4'h1;
    flush_nxt = flush_r;
    done_nxt  = 1'b0;
    lost_nxt  = 1'b0;
    popTx     = 1'b0;
    unique case (st_r)
      vpw_pkg::TX_IDLE: begin
        if (flush_r) begin
          popTx     = fifoValid;
          flush_nxt = !(fifoValid && head[9]);
        end else if (startSof) begin
          st_nxt  = vpw_pkg::TX_SOF;
          act_nxt = 1'b1;
          tmr_nxt = SOFC - 1'b1;
          grd_nxt = GRD;
        end else if (startNb) begin
          st_nxt  = vpw_pkg::TX_NB;
          act_nxt = 1'b1;
          tmr_nxt = bitDur(1'b1, NB_VALUE);
          grd_nxt = GRD;
        end
      end
      vpw_pkg::TX_SOF, vpw_pkg::TX_NB, vpw_pkg::TX_BIT: begin
        if (symEnd) begin
          act_nxt = !txActive;
          grd_nxt = GRD;
          e8_nxt  = st_r == vpw_pkg::TX_BIT && idx_r == 3'h7;
          if (st_r == vpw_pkg::TX_BIT && idx_r != 3'h7) begin
            sh_nxt  = {sh_r[6:0], 1'b0};
            idx_nxt = idx_r + 3'h1;
            tmr_nxt = bitDur(!txActive, sh_r[6]);
          end else if (st_r == vpw_pkg::TX_BIT &&
                       (last_r || !fifoValid)) begin
            st_nxt   = vpw_pkg::TX_EOD;
            tmr_nxt  = EODC - 1'b1;
            last_nxt = 1'b1;
          end else begin
            popTx    = 1'b1;
            st_nxt   = vpw_pkg::TX_BIT;
            sh_nxt   = head[7:0];
            last_nxt = head[9];
            idx_nxt  = 3'h0;
            tmr_nxt  = bitDur(!txActive, head[7]);
          end
        end
      end
      vpw_pkg::TX_EOD: begin
        if (symEnd) begin
          st_nxt   = vpw_pkg::TX_IDLE;
          done_nxt = 1'b1;
        end
      end
      vpw_pkg::TX_SYNC: begin
        // Extra bits follow the winner's timing from its falling edge
        if (!busLvl) begin
          st_nxt  = vpw_pkg::TX_EXTRA;
          idx_nxt = 3'h0;
          tmr_nxt = bitDur(1'b0, 1'b1);
          grd_nxt = GRD;
        end
      end
      vpw_pkg::TX_EXTRA: begin
        if (symEnd && idx_r == 3'h0) begin
          idx_nxt = 3'h1;
          act_nxt = 1'b1;
          tmr_nxt = bitDur(1'b1, 1'b1);
          grd_nxt = GRD;
        end else if (symEnd) begin
          st_nxt  = vpw_pkg::TX_IDLE;
          act_nxt = 1'b0;
        end
      end
      default: begin
        st_nxt  = vpw_pkg::TX_IDLE;
        act_nxt = 1'b0;
      end
    endcase
    // Loss releases the bus at once; unsent bytes of the frame are dropped
    if (abortEv) begin
      popTx     = 1'b0;
      act_nxt   = 1'b0;
      lost_nxt  = mismatch && st_r != vpw_pkg::TX_EXTRA;
      flush_nxt = flush_r || st_r == vpw_pkg::TX_SOF ||
                  st_r == vpw_pkg::TX_NB || !last_r;
      st_nxt    = loss8 ? vpw_pkg::TX_SYNC : vpw_pkg::TX_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r     <= vpw_pkg::TX_IDLE;
      txActive <= 1'b0;
      tmr_r    <= '0;
      sh_r     <= 8'h00;
      idx_r    <= 3'h0;
      last_r   <= 1'b0;
      e8_r     <= 1'b0;
      grd_r    <= 4'h0;
      flush_r  <= 1'b0;
      txDone   <= 1'b0;
      arbLost  <= 1'b0;
      txBusy   <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      txActive <= act_nxt;
      tmr_r    <= tmr_nxt;
      sh_r     <= sh_nxt;
      idx_r    <= idx_nxt;
      last_r   <= last_nxt;
      e8_r     <= e8_nxt;
      grd_r    <= grd_nxt;
      flush_r  <= flush_nxt;
      txDone   <= done_nxt;
      arbLost  <= lost_nxt;
      txBusy   <= st_nxt != vpw_pkg::TX_IDLE || flush_nxt;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic          prevAct_r;
  logic [CW-1:0] run_r;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prevAct_r <= 1'b0;
      run_r     <= '0;
    end else begin
      prevAct_r <= txActive;
      run_r     <= (txActive != prevAct_r) ? CW'(1) : run_r + 1'b1;
    end
  end

  a_sof_len: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(txActive) && $past(st_r) == vpw_pkg::TX_SOF && !$past(abortEv)
    |-> run_r == SOFC) else $error("start of frame length wrong");
  a_one_pas: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(txActive) && $past(st_r) == vpw_pkg::TX_BIT && $past(sh_r[7])
    && !$past(abortEv) |-> run_r == LONG)
    else $error("passive logic 1 length wrong");
  a_zero_act: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(txActive) && $past(st_r) == vpw_pkg::TX_BIT && !$past(sh_r[7])
    && !$past(abortEv) |-> run_r == LONG)
    else $error("active logic 0 length wrong");
  a_eod_len: assert property (@(posedge clk_sys) disable iff (rst)
    txDone |-> !txActive && run_r == EODC)
    else $error("end of data length wrong");
  a_no_break: assert property (@(posedge clk_sys) disable iff (rst)
    txActive && prevAct_r |-> run_r < BRKC)
    else $error("device drove a break");
  a_loss_stop: assert property (@(posedge clk_sys) disable iff (rst)
    mismatch && !loss8 |=> !txActive && st_r == vpw_pkg::TX_IDLE &&
    (arbLost || $past(st_r) == vpw_pkg::TX_EXTRA))
    else $error("drive kept after lost arbitration");
  a_eighth_ext: assert property (@(posedge clk_sys) disable iff (rst)
    loss8 |=> st_r == vpw_pkg::TX_SYNC && arbLost && !txActive)
    else $error("8th bit loss did not append bits");
  a_start_ok: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(txActive) && $past(st_r) == vpw_pkg::TX_IDLE
    |-> $past(busIdle || (eofSeen_r && rise) || eodTime))
    else $error("transmission began on a busy bus");
  a_rx_one: assert property (@(posedge clk_sys) disable iff (rst)
    rise && cnt > CW'(P_ZERO_MAX) && cnt <= CW'(P_ONE_MAX)
    |=> symValid && symCode == vpw_pkg::SYM_ONE)
    else $error("passive logic 1 misclassified");
  a_brk_seen: assert property (@(posedge clk_sys) disable iff (rst)
    busLvl && cnt == CW'(A_SOF_MAX + 1)
    |=> symCode == vpw_pkg::SYM_BRK ##1 !symValid)
    else $error("break not reported once");
  a_idle_set: assert property (@(posedge clk_sys) disable iff (rst)
    !busLvl && cnt == CW'(P_IFS_MAX + 1) && !rise |=> busIdle)
    else $error("idle not flagged after separation");
endmodule

// ==== design/vpw_codec_defs.svh ====
/*
  Constants of the variable pulse width symbol codec: timing figures in
  microseconds and the cycle counts derived from them.
  Assumes the codec clock runs at the rate given below.
*/
`ifndef VPW_CODEC_DEFS_SVH
`define VPW_CODEC_DEFS_SVH

// ****************************************************************
// Clock and nominal rate
// ****************************************************************
`define VPW_CLK_KHZ      10000
`define VPW_RATE_BPS     10400
`define VPW_CYC(us)      (((us) * `VPW_CLK_KHZ + 999) / 1000)

// ****************************************************************
// Nominal symbol times, microseconds
// ****************************************************************
`define VPW_T_SHORT_US   64
`define VPW_T_LONG_US    128
`define VPW_T_SOF_US     200
`define VPW_T_EOD_US     200
`define VPW_T_EOF_US     280
`define VPW_T_EOF_EXT_US 80
`define VPW_T_IFS_US     300
`define VPW_T_IFS_EXT_US 20
`define VPW_T_BRK_US     240

// ****************************************************************
// Receive window upper bounds, microseconds; transmit guard, cycles
// ****************************************************************
`define VPW_RX_INV_US    34
`define VPW_RX_SHORT_US  96
`define VPW_RX_LONG_US   163
`define VPW_GUARD_CYC    4
`endif

// ==== design/vpw_pkg.sv ====
/*
  Types shared by the symbol codec: received symbol codes and transmit
  states. Assumes nothing of its surroundings.
*/
package vpw_pkg;
  typedef enum logic [3:0] {
    SYM_NONE, SYM_ZERO, SYM_ONE, SYM_SOF, SYM_EOD, SYM_EOF,
    SYM_IFS, SYM_IDLE, SYM_BRK, SYM_INV
  } sym_t;
  typedef enum logic [2:0] {
    TX_IDLE, TX_SOF, TX_NB, TX_BIT, TX_EOD, TX_SYNC, TX_EXTRA
  } tx_state_t;
endpackage

// ==== design/vpw_fifo.sv ====
/*
  Small first-in first-out buffer with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module vpw_fifo #(
  parameter int W     = 10,
  parameter int DEPTH = 4
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] inData,
  input  wire logic         inValid,
  output logic              inReady,
  output logic [W-1:0]      outData,
  output logic              outValid,
  input  wire logic         outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("vpw_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0]   cnt_r;
  logic [AW:0]   cnt_nxt;
  wire           push = inValid && inReady;
  wire           pop  = outValid && outReady;

  assign outData = mem[rdPtr_r];
  assign cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  // Flags are registered so that ready leaves the block from a flop
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wrPtr_r  <= '0;
      rdPtr_r  <= '0;
      cnt_r    <= '0;
      inReady  <= 1'b1;
      outValid <= 1'b0;
    end else begin
      wrPtr_r  <= wrPtr_r + {{(AW-1){1'b0}}, push};
      rdPtr_r  <= rdPtr_r + {{(AW-1){1'b0}}, pop};
      cnt_r    <= cnt_nxt;
      inReady  <= cnt_nxt != (AW+1)'(DEPTH);
      outValid <= cnt_nxt != '0;
    end
  end
endmodule

// ==== design/vpw_rx_timer.sv ====
/*
  Synchronises the received bus line and measures how long its level has
  stood. Assumes the line is asynchronous to clk_sys; high means active.
*/
`timescale 1ns/10ps
module vpw_rx_timer #(
  parameter int CW = 12
) (
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire logic          lineIn,
  output logic               lvl,
  output logic               rise,
  output logic               fall,
  output logic [CW-1:0]      cnt
);
  logic          s1_r;
  logic          s2_r;
  logic          lvl_r;
  logic [CW-1:0] cnt_r;
  wire           chg = s2_r != lvl_r;

  assign lvl  = lvl_r;
  assign rise = s2_r && !lvl_r;
  assign fall = !s2_r && lvl_r;
  // On an edge cycle cnt still holds the length of the ended period
  assign cnt  = cnt_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_r  <= 1'b0;
      s2_r  <= 1'b0;
      lvl_r <= 1'b0;
      cnt_r <= '0;
    end else begin
      s1_r  <= lineIn;
      s2_r  <= s1_r;
      lvl_r <= s2_r;
      // Saturates so a stuck bus never wraps into a short window
      cnt_r <= chg ? CW'(1) : ((&cnt_r) ? cnt_r : cnt_r + 1'b1);
    end
  end
endmodule

// ==== tb/vpw_node.sv ====
/*
  Second bus node for the codec bench: wired-OR bus and timed levels.
  Assumes its tasks are called at falling edges of clk_sys.
*/
`timescale 1ns/10ps
module vpw_node (
  input  wire logic clk_sys,
  input  wire logic dutActive,
  output logic      rxLine
);
  // ****************************************************************
  // Partner node
  // ****************************************************************
  logic drv = 1'b0;
  // A released bus falls passive through the transceiver pull-down
  assign rxLine = drv | dutActive;
  task automatic hold(input logic lvl, input int cyc);
    drv = lvl;
    repeat (cyc) @(negedge clk_sys);
  endtask
  task automatic send(input logic [7:0] b);
    hold(1'b1, 2000);
    for (int i = 7; i >= 0; i--) begin
      hold(~i[0], (b[i] ^ ~i[0]) ? 1280 : 640);
    end
    hold(1'b0, 2000);
  endtask
endmodule

// ==== tb/tb.sv ====
/*
  Self-checking bench of the symbol codec: own and received frames,
  break, buffer fill, arbitration loss, 8th bit loss, response byte.
  Assumes default parameters.
*/
`timescale 1ns/10ps
module tb;
  // ****************************************************************
  // Bench
  // ****************************************************************
  logic          clk_sys, rst, rxLine, txLast, txIfr, txValid;
  logic [7:0]    txData, rxByte, lastByte, r;
  logic          txReady, txActive, txBusy, txDone, arbLost;
  logic          rxByteValid, symValid, busIdle;
  vpw_pkg::sym_t symCode;
  logic [7:0]    q[$];
  int            errors = 0, checked = 0, doneCnt = 0, lostCnt = 0;
  int            brkCnt = 0, actCnt = 0, a0, n, wt;
  vpw_codec u_dut (.clk_sys(clk_sys), .rst(rst), .rxLine(rxLine),
    .txData(txData), .txLast(txLast), .txIfr(txIfr), .txValid(txValid),
    .txReady(txReady), .txActive(txActive), .txBusy(txBusy),
    .txDone(txDone), .arbLost(arbLost), .rxByte(rxByte),
    .rxByteValid(rxByteValid), .symCode(symCode), .symValid(symValid),
    .busIdle(busIdle));
  vpw_node u_node (.clk_sys(clk_sys), .dutActive(txActive),
    .rxLine(rxLine));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (txDone) doneCnt <= doneCnt + 1;
    if (arbLost) lostCnt <= lostCnt + 1;
    if (symValid && symCode === vpw_pkg::SYM_BRK) brkCnt <= brkCnt + 1;
    if (rxByteValid) lastByte <= rxByte;
    if (txActive) actCnt <= actCnt + 1;
  end
  task automatic check(input string nm, input logic [31:0] exp, got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Counts falling edges until the level is reached; run-out ends the run
  task automatic waitc(input bit idle, input logic lvl, input int lim);
    n = 0;
    while ((idle ? busIdle : txActive) !== lvl) begin
      @(negedge clk_sys);
      n++;
      if (n > lim) begin
        errors++;
        tally_and_finish();
      end
    end
  endtask
  task automatic push(input logic [7:0] b, input logic last);
    txData = b;
    txLast = last;
    txValid = 1'b1;
    @(negedge clk_sys);
  endtask
  // Times every level of one sent frame of q
  task automatic frame(input int lim, input int sof);
    logic lvl;
    int   d0;
    waitc(0, 1'b1, lim);
    wt = n;
    d0 = doneCnt;
    waitc(0, 1'b0, 2100);
    check("sof", sof, n);
    lvl = 1'b0;
    foreach (q[k]) for (int i = 7; i >= 0; i--) begin
      waitc(0, ~lvl, 1400);
      check("bit", (q[k][i] ^ lvl) ? 1280 : 640, n);
      lvl = ~lvl;
    end
    repeat (1990) @(negedge clk_sys);
    check("eod", 0, doneCnt - d0);
    repeat (20) @(negedge clk_sys);
    check("done", 1, doneCnt - d0);
    check("echo", q[$], lastByte);
  endtask
  initial begin
    rst = 1'b1;
    {txData, txLast, txIfr, txValid} = 11'h000;
    n = $urandom(25964);
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    check("reset", 3'h4, {txReady, txActive, busIdle});
    waitc(1, 1'b1, 3100);
    check("idle", 1, n > 2995 && n < 3010);
    q = {8'($urandom)};
    push(q[0], 1'b1);
    txValid = 1'b0;
    frame(100, 2000);
    waitc(1, 1'b1, 4000);
    r = 8'($urandom);
    u_node.send(r);
    check("rx", r, lastByte);
    waitc(1, 1'b1, 4000);
    fork
      u_node.hold(1'b1, 2600);
    join_none
    repeat (10) @(negedge clk_sys);
    q = {8'hff, 8'($urandom), 8'($urandom), 8'h00};
    foreach (q[k]) push(q[k], k == 3);
    txValid = 1'b0;
    @(negedge clk_sys);
    check("full", 0, txReady);
    push(8'h55, 1'b1);
    txValid = 1'b0;
    repeat (2600) @(negedge clk_sys);
    u_node.drv = 1'b0;
    frame(7000, 2000);
    check("wait", 1, wt > 2900);
    check("break", 1, brkCnt);
    waitc(1, 1'b1, 4000);
    check("refused", 0, txBusy);
    push(8'hff, 1'b1);
    txValid = 1'b0;
    waitc(0, 1'b1, 100);
    u_node.hold(1'b1, 2000);
    u_node.hold(1'b0, 640);
    u_node.hold(1'b1, 30);
    check("lost", 2'h2, {lostCnt == 1, txActive});
    u_node.hold(1'b0, 10);
    a0 = actCnt;
    push(8'h01, 1'b1);
    txValid = 1'b0;
    waitc(0, 1'b1, 3200);
    u_node.send(8'h00);
    check("extra", 2000 + 3 * 1280 + 2 * 640, actCnt - a0);
    check("lost8", 2, lostCnt);
    waitc(1, 1'b1, 4000);
    q = {8'($urandom)};
    txIfr = 1'b1;
    push(q[0], 1'b1);
    {txValid, txIfr} = 2'h0;
    u_node.send(8'($urandom));
    frame(100, 1280);
    tally_and_finish();
  end
endmodule
